/* File: design/lpc_clock_divider.sv */
/*
  Package of shared constants for the link port block, and the link clock
  divider used by each link port in transmit mode.
  Assumes a single system clock that also serves as the link source clock,
  and a synchronous active-low reset.
*/
`timescale 1ns/1ps

package lpc_pkg;
  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int LPC_PORTS = 2;
  localparam int LPC_DATA_W = 8;
  localparam int LPC_DIV_W = 8;
  localparam int LPC_RX_DEPTH = 4;
  localparam int LPC_DIV_MAX = 255;
  localparam logic [LPC_DIV_W-1:0] LPC_DIV_BYPASS = 8'h00;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int LPC_SRC_CLK_MHZ = 50;
  localparam int LPC_SRC_CLK_PERIOD_NS = 1000 / LPC_SRC_CLK_MHZ;
  // Acknowledge low delay after link clock edge, in tenths of source periods
  localparam int LPC_ACK_DLY_MIN_X10 = 15;
  localparam int LPC_ACK_DLY_MAX_X10 = 25;
  localparam int LPC_ACK_DLY_MIN_CYC = (LPC_ACK_DLY_MIN_X10 + 9) / 10;
  localparam int LPC_ACK_DLY_MAX_CYC = LPC_ACK_DLY_MAX_X10 / 10;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic LPC_CLK_IDLE = 1'b1;
  localparam logic LPC_ACK_IDLE = 1'b1;
endpackage

module lpc_clock_divider
  import lpc_pkg::*;
#(
  parameter int DIV_W = LPC_DIV_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [DIV_W-1:0] div_value,
  // Divided clock
  output logic clk_level,
  output logic load_slot
);
  import lpc_pkg::*;

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic lvl_reg;
  logic lvl_next;
  logic wrap;

  // ****************************************************************
  // Half-period counter
  // ****************************************************************
  assign wrap = (cnt_reg == div_value - {{(DIV_W-1){1'b0}}, 1'b1});

  always_comb begin
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    if (!run || div_value == LPC_DIV_BYPASS) begin
      cnt_next = '0;
      lvl_next = LPC_CLK_IDLE;
    end else if (wrap) begin
      cnt_next = '0;
      lvl_next = ~lvl_reg;
    end else begin
      cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      lvl_reg <= LPC_CLK_IDLE;
    end else begin
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Bypass passes the source clock straight through; a new value each cycle
  assign clk_level = (div_value == LPC_DIV_BYPASS) ? (run ? sys_clk : LPC_CLK_IDLE) : lvl_reg; // R2
  // Slot where the clock is about to rise: period is twice the divide value
  assign load_slot = (div_value == LPC_DIV_BYPASS) ? run : (run && wrap && !lvl_reg); // R1
endmodule

/* File: design/lpc_link_port.sv */
/*
  Two independent parallel link ports. Each transmits with a divided clock
  or receives with the far end's clock, with acknowledge flow control.
  Assumes one system clock that is the link source clock; all link pins
  are asynchronous and pass two flip-flops before use.
*/
// Behaviour
// R1: Transmit clock is source divided by twice value
// R2: Divide value zero passes source clock through
// R3: In receive mode far end supplies clock
// R4: Data stable at falling edge, captured there
// R5: Acknowledge low 1.5 to 2.5 periods after edge (code: 2 to 3 periods, via the pin synchroniser and ack_reg)
// R6: After first byte, acknowledge low near full
// R7: Two identical independent link port instances
// R8: Transmitter pauses while acknowledge is low
`timescale 1ns/1ps

module lpc_link_port
  import lpc_pkg::*;
#(
  parameter int PORTS = LPC_PORTS,
  parameter int DATA_W = LPC_DATA_W,
  parameter int DIV_W = LPC_DIV_W,
  parameter int RX_DEPTH = LPC_RX_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Per-port configuration
  input wire logic [PORTS-1:0] transmit_mode,
  input wire logic [PORTS*DIV_W-1:0] link_divider_register,
  // Transmit user side
  input wire logic [PORTS*DATA_W-1:0] tx_data,
  input wire logic [PORTS-1:0] tx_valid,
  output logic [PORTS-1:0] tx_ready,
  // Receive user side
  output logic [PORTS*DATA_W-1:0] rx_data,
  output logic [PORTS-1:0] rx_valid,
  input wire logic [PORTS-1:0] rx_ready,
  output logic [PORTS-1:0] rx_overrun,
  // Link clock pin
  input wire logic [PORTS-1:0] link_clock_line_in,
  output logic [PORTS-1:0] link_clock_line_out,
  output logic [PORTS-1:0] link_clock_line_oe_n,
  // Link data pins
  input wire logic [PORTS*DATA_W-1:0] link_data_lines_in,
  output logic [PORTS*DATA_W-1:0] link_data_lines_out,
  output logic [PORTS*DATA_W-1:0] link_data_lines_oe_n,
  // Link acknowledge pin
  input wire logic [PORTS-1:0] link_acknowledge_line_in,
  output logic [PORTS-1:0] link_acknowledge_line_out,
  output logic [PORTS-1:0] link_acknowledge_line_oe_n
);
  import lpc_pkg::*;

  localparam int PTR_W = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_NEAR_FULL = CNT_W'(RX_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    logic [PTR_W-1:0] r;
    r = (p == PTR_W'(RX_DEPTH - 1)) ? '0 : p + PTR_W'(1);
    return r;
  endfunction

  genvar g;
  generate
    for (g = 0; g < PORTS; g = g + 1) begin : gen_port // R7
      // ****************************************************************
      // Pin synchronisers
      // ****************************************************************
      logic clk_s1_reg;
      logic clk_s2_reg;
      logic clk_s3_reg;
      logic ack_s1_reg;
      logic ack_s2_reg;
      logic [DATA_W-1:0] dat_s1_reg;
      logic [DATA_W-1:0] dat_s2_reg;

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          clk_s1_reg <= LPC_CLK_IDLE;
          clk_s2_reg <= LPC_CLK_IDLE;
          clk_s3_reg <= LPC_CLK_IDLE;
          ack_s1_reg <= LPC_ACK_IDLE;
          ack_s2_reg <= LPC_ACK_IDLE;
          dat_s1_reg <= '0;
          dat_s2_reg <= '0;
        end else begin
          clk_s1_reg <= link_clock_line_in[g];
          clk_s2_reg <= clk_s1_reg;
          clk_s3_reg <= clk_s2_reg;
          ack_s1_reg <= link_acknowledge_line_in[g];
          ack_s2_reg <= ack_s1_reg;
          dat_s1_reg <= link_data_lines_in[g*DATA_W +: DATA_W];
          dat_s2_reg <= dat_s1_reg;
        end
      end

      // ****************************************************************
      // Transmitter
      // ****************************************************************
      logic tx_mode;
      logic run_reg;
      logic run_next;
      logic [DATA_W-1:0] txd_reg;
      logic [DATA_W-1:0] txd_next;
      logic clk_level;
      logic load_slot;
      logic tx_take;

      assign tx_mode = transmit_mode[g];

      lpc_clock_divider #(
        .DIV_W(DIV_W)
      ) u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(run_reg),
        .div_value(link_divider_register[g*DIV_W +: DIV_W]),
        .clk_level(clk_level),
        .load_slot(load_slot)
      );

      // New byte while stopped or at a rising slot, and only while acknowledge is high
      assign tx_ready[g] = tx_mode && ack_s2_reg && (!run_reg || load_slot); // R8
      assign tx_take = tx_ready[g] && tx_valid[g];

      always_comb begin
        run_next = run_reg;
        txd_next = txd_reg;
        if (!tx_mode) begin
          run_next = 1'b0;
        end else if (tx_take) begin
          run_next = 1'b1;
          txd_next = tx_data[g*DATA_W +: DATA_W];
        end else if (load_slot) begin
          run_next = 1'b0; // R8
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          run_reg <= 1'b0;
          txd_reg <= '0;
        end else begin
          run_reg <= run_next;
          txd_reg <= txd_next;
        end
      end

      // Data changes with the rising clock so it is steady at the fall
      assign link_clock_line_out[g] = tx_mode ? clk_level : LPC_CLK_IDLE; // R1
      assign link_data_lines_out[g*DATA_W +: DATA_W] = txd_reg; // R4
      assign link_clock_line_oe_n[g] = ~tx_mode; // R3
      assign link_data_lines_oe_n[g*DATA_W +: DATA_W] = {DATA_W{~tx_mode}};
      assign link_acknowledge_line_oe_n[g] = tx_mode;

      // ****************************************************************
      // Receiver
      // ****************************************************************
      logic [DATA_W-1:0] buf_reg [RX_DEPTH];
      logic [DATA_W-1:0] buf_next [RX_DEPTH];
      logic [PTR_W-1:0] wr_reg;
      logic [PTR_W-1:0] wr_next;
      logic [PTR_W-1:0] rd_reg;
      logic [PTR_W-1:0] rd_next;
      logic [CNT_W-1:0] cnt_reg;
      logic [CNT_W-1:0] cnt_next;
      logic first_reg;
      logic first_next;
      logic ack_reg;
      logic ack_next;
      logic ovr_reg;
      logic ovr_next;
      logic fall;
      logic push;
      logic pop;

      // Far-end clock is sampled, never used as a clock here
      assign fall = !tx_mode && clk_s3_reg && !clk_s2_reg; // R3 R4
      assign push = fall && (cnt_reg != CNT_FULL);
      assign pop = rx_valid[g] && rx_ready[g];

      always_comb begin
        buf_next = buf_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        first_next = first_reg;
        ovr_next = fall && (cnt_reg == CNT_FULL);
        if (push) begin
          buf_next[wr_reg] = dat_s2_reg; // R4
          wr_next = ptr_inc(wr_reg);
          first_next = 1'b1;
        end
        if (pop) begin
          rd_next = ptr_inc(rd_reg);
        end
        if (push && !pop) begin
          cnt_next = cnt_reg + CNT_W'(1);
        end else if (pop && !push) begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
        if (tx_mode) begin
          first_next = 1'b0;
        end
        // Registered one cycle after the detected edge: 2 to 3 source periods
        ack_next = !(first_next && cnt_next >= CNT_NEAR_FULL); // R5 R6
      end

      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          for (int i = 0; i < RX_DEPTH; i++) begin
            buf_reg[i] <= '0;
          end
          wr_reg <= '0;
          rd_reg <= '0;
          cnt_reg <= '0;
          first_reg <= 1'b0;
          ack_reg <= LPC_ACK_IDLE;
          ovr_reg <= 1'b0;
        end else begin
          buf_reg <= buf_next;
          wr_reg <= wr_next;
          rd_reg <= rd_next;
          cnt_reg <= cnt_next;
          first_reg <= first_next;
          ack_reg <= ack_next;
          ovr_reg <= ovr_next;
        end
      end

      assign rx_valid[g] = (cnt_reg != '0);
      assign rx_data[g*DATA_W +: DATA_W] = buf_reg[rd_reg];
      assign rx_overrun[g] = ovr_reg;
      assign link_acknowledge_line_out[g] = ack_reg; // R6
    end
  endgenerate
endmodule

/* File: bench/lpc_link_port_asserts.sv */
/*
  Checker for the link port block, bound to its top module.
  Assumes one system clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module lpc_checker #(
  parameter int PORTS = 2,
  parameter int DATA_W = 8,
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // User side
  input wire logic [PORTS-1:0] transmit_mode,
  input wire logic [PORTS*DIV_W-1:0] link_divider_register,
  input wire logic [PORTS*DATA_W-1:0] tx_data,
  input wire logic [PORTS-1:0] tx_valid,
  input wire logic [PORTS-1:0] tx_ready,
  input wire logic [PORTS-1:0] rx_valid,
  // Link pins
  input wire logic [PORTS-1:0] link_clock_line_in,
  input wire logic [PORTS-1:0] link_clock_line_out,
  input wire logic [PORTS-1:0] link_clock_line_oe_n,
  input wire logic [PORTS*DATA_W-1:0] link_data_lines_out,
  input wire logic [PORTS-1:0] link_acknowledge_line_in,
  input wire logic [PORTS-1:0] link_acknowledge_line_out,
  input wire logic [PORTS-1:0] link_acknowledge_line_oe_n
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_div_one_low: assert property ($fell(link_clock_line_out[0]) && link_divider_register[7:0] == 8'h01
    |=> link_clock_line_out[0]) else $error("link clock low too long");
  a_tx_pins_driven: assert property (transmit_mode[0] && $past(transmit_mode[0]) && $past(rst_n)
    |-> !link_clock_line_oe_n[0] && link_acknowledge_line_oe_n[0]) else $error("transmit pins wrong");
  a_rx_pins_released: assert property (!transmit_mode[0] && !$past(transmit_mode[0]) && $past(rst_n)
    |-> link_clock_line_oe_n[0] && !link_acknowledge_line_oe_n[0]) else $error("receive pins wrong");
  a_take_data_out: assert property (tx_valid[0] && tx_ready[0]
    |=> link_data_lines_out[7:0] == $past(tx_data[7:0])) else $error("data not sent");
  a_fall_data_stable: assert property ($fell(link_clock_line_out[0]) && link_divider_register[7:0] != 8'h00
    |-> $stable(link_data_lines_out[7:0])) else $error("data moved at fall");
  a_ack_fall_delay: assert property ($fell(link_acknowledge_line_out[0])
    |-> !$past(link_clock_line_in[0], 2) && ($past(link_clock_line_in[0], 3) || $past(link_clock_line_in[0], 4)))
    else $error("acknowledge delay wrong");
  a_ack_low_full: assert property (!link_acknowledge_line_out[0] |-> rx_valid[0])
    else $error("acknowledge low while empty");
  a_ack_stall_ready: assert property (!link_acknowledge_line_in[0] [*3] |-> !tx_ready[0])
    else $error("ready while stalled");
  a_port1_rx_ready: assert property (!transmit_mode[1] |-> !tx_ready[1])
    else $error("second port ready in receive");
  c_take: cover property (tx_valid[0] && tx_ready[0]);
  c_clock_fall: cover property ($fell(link_clock_line_out[0]));
  c_ack_low: cover property ($fell(link_acknowledge_line_out[0]));
endmodule

bind lpc_link_port lpc_checker #(.PORTS(PORTS), .DATA_W(DATA_W), .DIV_W(DIV_W)) lpc_checker_inst (.*);

/* File: bench/lpc_far_end.sv */
/*
  Far-end link port model: receives with the block's clock, or transmits
  with its own slow clock. Assumes resolved pin levels from the bench.
*/
`timescale 1ns/1ps
module lpc_far_end (
  // Clock
  input wire logic sys_clk,
  // Resolved pins
  input wire logic clk_w,
  input wire logic [7:0] dat_w,
  input wire logic ack_w,
  // Far-end drivers
  output logic clk_d,
  output logic [7:0] dat_d,
  output logic ack_d,
  // Control and results
  input wire logic rx_on,
  input wire logic stall,
  output logic [23:0] cap,
  output int n_cap,
  output int gap
);
  // ****************************************************************
  // Behaviour
  // ****************************************************************
  int cnt = 0;
  int last = 0;
  initial begin
    clk_d = 1'b1;
    dat_d = 8'h5A;
    cap = '0;
    n_cap = 0;
    gap = 0;
  end
  assign ack_d = !stall;
  always @(posedge sys_clk) cnt <= cnt + 1;
  always @(negedge clk_w) if (rx_on) begin
    cap <= {cap[15:0], dat_w};
    n_cap <= n_cap + 1;
    gap <= cnt - last;
    last <= cnt;
  end
  task automatic send(input logic [7:0] b, input bit obey);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1 k++;
    end while (obey && ack_w !== 1'b1 && k < 500);
    dat_d = b;
    repeat (4) @(posedge sys_clk);
    #1 clk_d = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 clk_d = 1'b1;
    dat_d = ~b;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

/* File: bench/lpc_link_port_tb.sv */
/*
  Testbench for the link port block with a far-end model on each port.
  Assumes the package constants: two ports, byte data, buffer depth four.
*/
`timescale 1ns/1ps
module lpc_link_port_tb;
  // ****************************************************************
  // Bench
  // ****************************************************************
  logic sys_clk = 0;
  logic rst_n = 0;
  logic [1:0] transmit_mode = 0, tx_valid = 0, rx_ready = 0, stall = 0;
  logic [15:0] link_divider_register = 0, tx_data = 0;
  logic [1:0] tx_ready, rx_valid, rx_overrun, link_clock_line_out, link_clock_line_oe_n, clk_d, ack_d;
  logic [1:0] link_acknowledge_line_out, link_acknowledge_line_oe_n, link_clock_line_in, link_acknowledge_line_in;
  logic [15:0] rx_data, link_data_lines_out, link_data_lines_oe_n, dat_d, link_data_lines_in;
  logic [23:0] cap[2];
  logic [7:0] divs[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
  int n_cap[2], gap[2];
  int n_fail = 0, check_count = 0, cyc = 0, n_ovr = 0;
  assign link_clock_line_in = (link_clock_line_oe_n & clk_d) | (~link_clock_line_oe_n & link_clock_line_out);
  assign link_data_lines_in = (link_data_lines_oe_n & dat_d) | (~link_data_lines_oe_n & link_data_lines_out);
  assign link_acknowledge_line_in = (link_acknowledge_line_oe_n & ack_d)
    | (~link_acknowledge_line_oe_n & link_acknowledge_line_out);
  lpc_link_port lpc_link_port_inst (.*);
  lpc_far_end lpc_far_end_inst0 (.sys_clk, .clk_w(link_clock_line_in[0]), .dat_w(link_data_lines_in[7:0]),
    .ack_w(link_acknowledge_line_in[0]), .clk_d(clk_d[0]), .dat_d(dat_d[7:0]), .ack_d(ack_d[0]),
    .rx_on(transmit_mode[0]), .stall(stall[0]), .cap(cap[0]), .n_cap(n_cap[0]), .gap(gap[0]));
  lpc_far_end lpc_far_end_inst1 (.sys_clk, .clk_w(link_clock_line_in[1]), .dat_w(link_data_lines_in[15:8]),
    .ack_w(link_acknowledge_line_in[1]), .clk_d(clk_d[1]), .dat_d(dat_d[15:8]), .ack_d(ack_d[1]),
    .rx_on(transmit_mode[1]), .stall(stall[1]), .cap(cap[1]), .n_cap(n_cap[1]), .gap(gap[1]));
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rx_overrun[0] === 1'b1) n_ovr <= n_ovr + 1;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic put(input int p, input logic [7:0] b);
    int k;
    k = 0;
    tx_data[p*8+:8] = b;
    tx_valid[p] = 1'b1;
    do begin
      @(negedge sys_clk);
      k++;
    end while (tx_ready[p] !== 1'b1 && k < 1000);
    tick(1);
  endtask
  task automatic t_tx(input int p, input logic [7:0] d);
    int n0;
    transmit_mode[p] = 1'b1;
    link_divider_register[p*8+:8] = d;
    tick(4);
    chk(link_data_lines_oe_n[p*8+:8], 8'h00);
    n0 = n_cap[p];
    put(p, d ^ 8'hA5);
    put(p, ~d);
    put(p, d + 8'h01);
    tx_valid[p] = 1'b0;
    tick(2 * d + 6);
    chk(n_cap[p] - n0, 3);
    chk(cap[p], {d ^ 8'hA5, ~d, d + 8'h01});
    chk(gap[p], (d == 0) ? 1 : 2 * d);
  endtask
  task automatic t_stall();
    int n0;
    n0 = n_cap[0];
    stall[0] = 1'b1;
    link_divider_register[7:0] = 8'h01;
    tick(4);
    tx_data[7:0] = 8'h3C;
    tx_valid[0] = 1'b1;
    tick(12);
    chk(tx_ready[0], 1'b0);
    chk(n_cap[0] - n0, 0);
    stall[0] = 1'b0;
    put(0, 8'h3C);
    tx_valid[0] = 1'b0;
    tick(8);
    chk(cap[0][7:0], 8'h3C);
    chk(n_cap[0] - n0, 1);
  endtask
  task automatic t_ovr();
    int n0;
    n0 = n_ovr;
    for (int i = 0; i < 5; i++) lpc_far_end_inst0.send(8'h90 + i[7:0], 1'b0);
    chk(n_ovr - n0, 1);
    chk(rx_data[7:0], 8'h90);
    rx_ready[0] = 1'b1;
    tick(4);
    rx_ready[0] = 1'b0;
    chk(rx_valid[0], 1'b0);
    chk(link_acknowledge_line_out[0], 1'b1);
  endtask
  task automatic t_rx(input int p);
    logic [31:0] got;
    int n;
    transmit_mode[p] = 1'b0;
    tick(4);
    chk({link_clock_line_oe_n[p], link_data_lines_oe_n[p*8+:8]}, 9'h1FF);
    got = 0;
    n = 0;
    fork
      for (int i = 0; i < 4; i++) begin
        if (p == 1) lpc_far_end_inst1.send(8'hC0 + i[7:0], 1'b1);
        else lpc_far_end_inst0.send(8'hC0 + i[7:0], 1'b1);
      end
      begin
        tick(20);
        chk(link_acknowledge_line_out[p], 1'b1);
        tick(40);
        chk(link_acknowledge_line_out[p], 1'b0);
        chk(rx_valid[p], 1'b1);
        rx_ready[p] = 1'b1;
        for (int k = 0; k < 300 && n < 4; k++) begin
          @(negedge sys_clk);
          if (rx_valid[p] === 1'b1) begin
            got = {got[23:0], rx_data[p*8+:8]};
            n++;
          end
        end
        tick(1);
        rx_ready[p] = 1'b0;
      end
    join
    chk(got, 32'hC0C1C2C3);
  endtask
  initial begin
    tick(12);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) t_tx(0, divs[i]);
    t_stall();
    t_rx(0);
    t_ovr();
    t_tx(1, 8'h02);
    t_rx(1);
    close_out();
  end
endmodule
